// File: hdl/multidrop_logon_map.svh
// Constants for the multidrop logon and selection block
`ifndef MULTIDROP_LOGON_MAP_SVH
`define MULTIDROP_LOGON_MAP_SVH
`define CHAR_SLASH      8'h2f
`define CHAR_COMMA      8'h2c
`define CHAR_CR         8'h0d
`define CHAR_ZERO       8'h30
`define CHAR_NINE       8'h39
`define NULL_CHAR       8'h00
`define ADDR_MAX        8'hfe
`define ADDR_P2P        8'hff
`define MAX_DIGITS      2'h3
`define RST_SELECTED    1'b0
`define SW_SETTLE       2'h2
`define FIFO_WIDTH      8
`define FIFO_DEPTH      16
`endif

// File: hdl/multidrop_logon_pkg.sv
// Types for the multidrop logon and selection block
package multidrop_logon_pkg;
  typedef enum logic [1:0] {
    PARSE_IDLE,
    PARSE_DIGITS
  } parse_state_t;
endpackage : multidrop_logon_pkg

// File: hdl/rx_line_fifo.sv
// Parameterised first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module rx_line_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0]   wr_ptr;
    logic [AW:0]   rd_ptr;
  } fifo_state_t;
  fifo_state_t       st;
  fifo_state_t       next_st;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              full;
  logic              empty;
  logic              push;
  logic              pop;

  assign full      = (st.wr_ptr[AW] != st.rd_ptr[AW]) && (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
  assign empty     = st.wr_ptr == st.rd_ptr;
  assign in_ready  = !full && !flush;
  assign out_valid = !empty && !flush;
  assign out_data  = mem[st.rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (flush) begin
      next_st.rd_ptr = st.wr_ptr;
    end else begin
      if (push) next_st.wr_ptr = st.wr_ptr + 1'b1;
      if (pop) next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : rx_line_fifo

// File: hdl/multidrop_logon_select.sv
// Logon decoder, selection state and channel gating for a multidrop subsystem
`timescale 1ns/1ps
`include "multidrop_logon_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Switch decoded inverted; addresses 0 to 254.
// - Address 255 selects point-to-point mode.
// - Switch sampled only after power-up reset.
// - Up to three digits; non-digit ends address.
// - Match selects; transmitter enabled when sending.
// - Transmitter disabled until own logon seen.
// - Other address logon deselects, disables transmitter.
// - Selected flag updated after every logon.
// - At most one subsystem drives the line.
// - Deselected: characters withheld, poll returns zero.
// - Line read stalls until selected and CR.
// - Output paced by point-to-point only, never by multidrop.
// - Switch-derived address is readable.
// - Character in progress finishes before disable.
// - Logon mid-line discards the partial line.
// - Output to point-to-point always; multidrop when selected.
module multidrop_logon_select
  import multidrop_logon_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] address_switch,
  output logic [7:0]      subsystem_addr,
  output logic            p2p_mode,
  output logic            selected_flag,
  output logic            logon_seen,
  input  wire logic [7:0] rx_char,
  input  wire logic       rx_valid,
  output logic            rx_ready,
  input  wire logic       char_poll_function,
  output logic [7:0]      poll_char,
  output logic            poll_done,
  input  wire logic       line_req,
  output logic [7:0]      line_char,
  output logic            line_char_valid,
  output logic            line_done,
  output logic            line_redo,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      p2p_tx_char,
  output logic            p2p_tx_start,
  input  wire logic       p2p_tx_busy,
  output logic [7:0]      md_tx_char,
  output logic            md_tx_start,
  input  wire logic       md_tx_busy,
  output logic            md_tx_enable
);

  typedef struct packed {
    logic [1:0]   settle;
    logic         strap_taken;
    logic [7:0]   addr;
    logic         p2p;
    logic         selected;
    parse_state_t pstate;
    logic [9:0]   acc;
    logic [1:0]   ndig;
    logic         logon_pulse;
    logic         in_line;
    logic         redo;
    logic         hold_tx;
    logic [7:0]   poll_q;
    logic         poll_q_done;
    logic [7:0]   out_q;
    logic         out_p2p;
    logic         out_md;
  } sel_state_t;

  sel_state_t st;
  sel_state_t next_st;
  logic [7:0] sw_s1;
  logic [7:0] sw_s2;
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_ready;
  logic       fifo_in_ready;
  logic       fifo_push;
  logic       fifo_flush;
  logic       rx_take;
  logic       is_digit;

  function automatic logic digit_char(input logic [7:0] c);
    return (c >= `CHAR_ZERO) && (c <= `CHAR_NINE);
  endfunction : digit_char

  ////////////////////////////////////////////////////////////////////////////
  // Switch synchroniser; second stage only is read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_s1 <= 8'h00;
      sw_s2 <= 8'h00;
    end else begin
      sw_s1 <= address_switch;
      sw_s2 <= sw_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path: logon characters are consumed, data goes to the line buffer
  assign is_digit = digit_char(rx_char);
  assign rx_ready = st.strap_taken && (fifo_in_ready || st.pstate == PARSE_DIGITS
                    || (!st.p2p && rx_char == `CHAR_SLASH) || (!st.p2p && !st.selected));
  assign rx_take  = rx_valid && rx_ready;
  // Deselected data is dropped, not buffered, so nothing stale survives
  assign fifo_push  = rx_take && st.pstate == PARSE_IDLE
                      && (st.p2p || rx_char != `CHAR_SLASH)
                      && (st.p2p || st.selected);
  assign fifo_flush = st.logon_pulse;
  assign fifo_ready = line_req && (st.p2p || st.selected);

  rx_line_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .flush    (fifo_flush),
    .in_data  (rx_char),
    .in_valid (fifo_push),
    .in_ready (fifo_in_ready),
    .out_data (fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st             = st;
    next_st.logon_pulse = 1'b0;
    next_st.poll_q_done = 1'b0;
    next_st.out_p2p     = 1'b0;
    next_st.out_md      = 1'b0;
    // Both synchroniser stages must hold the switch before it is latched
    if (!st.strap_taken) begin
      if (st.settle == `SW_SETTLE) begin
        next_st.strap_taken = 1'b1;
        next_st.addr        = ~sw_s2;
        next_st.p2p         = (~sw_s2 == `ADDR_P2P);
      end else begin
        next_st.settle = st.settle + 2'h1;
      end
    end
    if (rx_take && !st.p2p) begin
      case (st.pstate)
        PARSE_IDLE: begin
          if (rx_char == `CHAR_SLASH) begin
            next_st.pstate = PARSE_DIGITS;
            next_st.acc    = 10'h000;
            next_st.ndig   = 2'h0;
          end
        end
        PARSE_DIGITS: begin
          if (is_digit && st.ndig < `MAX_DIGITS) begin
            next_st.acc  = 10'((st.acc * 10'd10) + {2'b00, rx_char - `CHAR_ZERO});
            next_st.ndig = st.ndig + 2'h1;
          end else begin
            next_st.pstate = PARSE_IDLE;
            if (st.ndig != 2'h0 && st.acc <= {2'b00, `ADDR_MAX}) begin
              next_st.selected    = (st.acc[7:0] == st.addr);
              next_st.logon_pulse = 1'b1;
              next_st.redo        = st.in_line;
              next_st.in_line     = 1'b0;
            end
          end
        end
        default: next_st.pstate = PARSE_IDLE;
      endcase
    end
    if (fifo_push) begin
      next_st.in_line = (rx_char != `CHAR_CR);
    end
    // A logon in the same cycle wins over the clear
    if (line_req && fifo_valid && fifo_ready && fifo_data == `CHAR_CR && !next_st.logon_pulse) begin
      next_st.redo = 1'b0;
    end
    // Poll returns at once; zero while withheld
    if (char_poll_function) begin
      next_st.poll_q_done = 1'b1;
      next_st.poll_q      = (fifo_valid && (st.p2p || st.selected)) ? fifo_data : `NULL_CHAR;
    end
    // Output: always sent to point-to-point; mirrors to multidrop only while selected
    if (tx_valid && tx_ready) begin
      next_st.out_q   = tx_char;
      next_st.out_p2p = 1'b1;
      next_st.out_md  = st.selected && !st.p2p;
    end
    if (st.out_md) begin
      next_st.hold_tx = 1'b1;
    end else if (st.hold_tx && !md_tx_busy) begin
      next_st.hold_tx = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st          <= '0;
      st.selected <= `RST_SELECTED;
      st.pstate   <= PARSE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign subsystem_addr  = st.addr;
  assign p2p_mode        = st.p2p;
  assign selected_flag   = st.selected;
  assign logon_seen      = st.logon_pulse;
  assign poll_char       = st.poll_q;
  assign poll_done       = st.poll_q_done;
  assign line_char       = fifo_data;
  assign line_char_valid = fifo_valid && fifo_ready;
  assign line_done       = line_char_valid && fifo_data == `CHAR_CR;
  assign line_redo       = st.redo;
  // The point-to-point channel paces output; multidrop never stalls it
  assign tx_ready        = !p2p_tx_busy && !st.out_p2p;
  assign p2p_tx_char     = st.out_q;
  assign p2p_tx_start    = st.out_p2p;
  assign md_tx_char      = st.out_q;
  assign md_tx_start     = st.out_md;
  // Driver stays on while a started character is still shifting out
  assign md_tx_enable    = !st.p2p && (st.selected || st.out_md || st.hold_tx)
                           && (st.out_md || st.hold_tx || md_tx_busy);

  ////////////////////////////////////////////////////////////////////////////
  property p_no_md_before_select;
    @(posedge core_clk) disable iff (!rst_n)
      md_tx_start |-> $past(selected_flag);
  endproperty
  a_no_md_before_select: assert property (p_no_md_before_select) else $error("multidrop start while deselected");

  property p_p2p_always;
    @(posedge core_clk) disable iff (!rst_n)
      (tx_valid && tx_ready) |=> p2p_tx_start && p2p_tx_char == $past(tx_char);
  endproperty
  a_p2p_always: assert property (p_p2p_always) else $error("output missed point-to-point channel");

  property p_poll_null;
    @(posedge core_clk) disable iff (!rst_n)
      (char_poll_function && !selected_flag && !p2p_mode) |=> poll_done && poll_char == 8'h00;
  endproperty
  a_poll_null: assert property (p_poll_null) else $error("poll not null while deselected");

  property p_no_line_deselected;
    @(posedge core_clk) disable iff (!rst_n)
      (!selected_flag && !p2p_mode) |-> !line_char_valid;
  endproperty
  a_no_line_deselected: assert property (p_no_line_deselected) else $error("line data while deselected");

  property p_addr_stable;
    @(posedge core_clk) disable iff (!rst_n)
      st.strap_taken ##1 st.strap_taken |-> $stable(subsystem_addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address changed after power-up");

  property p_select_only_on_logon;
    @(posedge core_clk) disable iff (!rst_n)
      $changed(selected_flag) |-> logon_seen;
  endproperty
  a_select_only_on_logon: assert property (p_select_only_on_logon) else $error("selected changed without logon");

  property p_hold_finishes;
    @(posedge core_clk) disable iff (!rst_n)
      (md_tx_busy && st.hold_tx) |-> md_tx_enable;
  endproperty
  a_hold_finishes: assert property (p_hold_finishes) else $error("driver cut mid character");

  property p_p2p_never_md;
    @(posedge core_clk) disable iff (!rst_n)
      p2p_mode |-> !md_tx_enable && !selected_flag;
  endproperty
  a_p2p_never_md: assert property (p_p2p_never_md) else $error("multidrop active in point-to-point mode");

  c_logon: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(selected_flag));
  c_deselect: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(selected_flag));
  c_line: cover property (@(posedge core_clk) disable iff (!rst_n) line_done);
  c_redo: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(line_redo));
endmodule : multidrop_logon_select

// File: verification/multidrop_master_model.sv
// Multidrop master and serialiser timing model facing the logon block
`timescale 1ns/1ps
module multidrop_master_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] busy_len,
  output logic [7:0]      rx_char,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic       p2p_tx_start,
  output logic            p2p_tx_busy,
  input  wire logic       md_tx_start,
  output logic            md_tx_busy
);
  int pl = 0;
  int ml = 0;
  int stalls = 0;
  initial begin
    rx_char     = 8'h00;
    rx_valid    = 1'b0;
    p2p_tx_busy = 1'b0;
    md_tx_busy  = 1'b0;
  end
  // Sampled mid-cycle so a start pulse is never raced; large busy_len is a slow line
  always @(negedge core_clk) begin
    pl = p2p_tx_start ? busy_len : (pl > 0 ? pl - 1 : 0);
    ml = md_tx_start ? busy_len : (ml > 0 ? ml - 1 : 0);
    p2p_tx_busy <= pl > 0;
    md_tx_busy  <= ml > 0;
  end
  // Sole driver of the line; char stands until taken or 60 cycles pass, then the line is scrambled
  task automatic send(input logic [7:0] c);
    int n;
    n = 0;
    rx_char  <= c;
    rx_valid <= 1'b1;
    @(negedge core_clk);
    while (rx_ready !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 60) stalls++;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
    @(posedge core_clk);
  endtask : send
endmodule : multidrop_master_model

// File: verification/multidrop_logon_select_tb_top.sv
// Self-checking bench with a reference model for the multidrop logon block
`timescale 1ns/1ps
module multidrop_logon_select_tb_top;
  logic [7:0] address_switch, subsystem_addr, rx_char, poll_char, line_char;
  logic [7:0] tx_char, p2p_tx_char, md_tx_char, busy_len, m_addr;
  logic       core_clk, rst_n, p2p_mode, selected_flag, logon_seen, rx_valid, rx_ready;
  logic       char_poll_function, poll_done, line_req, line_char_valid, line_done, line_redo;
  logic       tx_valid, tx_ready, p2p_tx_start, p2p_tx_busy, md_tx_start, md_tx_busy, md_tx_enable;
  logic       m_sel, m_p2p, m_redo;
  int         err_count, compares, seen_cnt, st, nd, val, a;
  logic [7:0] mq[$];

  multidrop_logon_select uut (.core_clk, .rst_n, .address_switch, .subsystem_addr, .p2p_mode,
    .selected_flag, .logon_seen, .rx_char, .rx_valid, .rx_ready, .char_poll_function, .poll_char,
    .poll_done, .line_req, .line_char, .line_char_valid, .line_done, .line_redo, .tx_char, .tx_valid,
    .tx_ready, .p2p_tx_char, .p2p_tx_start, .p2p_tx_busy, .md_tx_char, .md_tx_start, .md_tx_busy,
    .md_tx_enable);
  multidrop_master_model mm (.core_clk, .busy_len, .rx_char, .rx_valid, .rx_ready, .p2p_tx_start,
    .p2p_tx_busy, .md_tx_start, .md_tx_busy);

  always #10 core_clk = ~core_clk;
  always @(negedge core_clk) if (logon_seen === 1'b1) seen_cnt++;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte
  task automatic check_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : check_bit
  task automatic model_rx(input logic [7:0] c);
    if (m_p2p || (st == 0 && c != 8'h2f)) begin
      if (m_p2p || m_sel) mq.push_back(c);
    end else if (st == 0) begin
      st = 1;
      nd = 0;
      val = 0;
    end else if (c >= 8'h30 && c <= 8'h39 && nd < 3) begin
      val = val * 10 + c - 8'h30;
      nd++;
    end else begin
      st = 0;
      if (nd > 0 && val <= 254) begin
        m_sel = val == m_addr;
        m_redo = mq.size() > 0;
        mq.delete();
      end
    end
  endtask : model_rx
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      model_rx(s[i]);
      mm.send(s[i]);
    end
  endtask : send_str
  task automatic logon(input string s, input int exp_seen);
    int c0;
    c0 = seen_cnt;
    send_str(s);
    repeat (2) @(posedge core_clk);
    check_byte("logon_seen count", 8'(exp_seen), 8'(seen_cnt - c0));
    check_bit("selected_flag", m_sel, selected_flag);
  endtask : logon
  task automatic poll;
    char_poll_function <= 1'b1;
    @(posedge core_clk);
    char_poll_function <= 1'b0;
    @(negedge core_clk);
    check_bit("poll_done", 1'b1, poll_done);
    check_byte("poll_char", (m_sel && mq.size() > 0) ? mq[0] : 8'h00, poll_char);
    @(posedge core_clk);
  endtask : poll
  task automatic read_line;
    int n;
    logic [7:0] e;
    n = 0;
    line_req <= 1'b1;
    do begin
      @(negedge core_clk);
      n++;
      if (line_char_valid === 1'b1) begin
        e = mq.pop_front();
        check_byte("line_char", e, line_char);
        check_bit("line_done", e == 8'h0d, line_done);
      end
    end while (line_done !== 1'b1 && n < 60);
    check_bit("line ended", 1'b1, line_done);
    @(posedge core_clk);
    line_req <= 1'b0;
    @(posedge core_clk);
  endtask : read_line
  task automatic send_tx(input logic [7:0] c);
    int n;
    n = 0;
    tx_char  <= c;
    tx_valid <= 1'b1;
    @(negedge core_clk);
    while (tx_ready !== 1'b1 && n < 80) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    tx_valid <= 1'b0;
    @(negedge core_clk);
    check_bit("p2p_tx_start", 1'b1, p2p_tx_start);
    check_byte("p2p_tx_char", c, p2p_tx_char);
    check_bit("md_tx_start", m_sel, md_tx_start);
    check_byte("md_tx_char", c, md_tx_char);
    check_bit("md_tx_enable", m_sel, md_tx_enable);
    @(posedge core_clk);
  endtask : send_tx
  task automatic do_reset(input logic [7:0] sw);
    address_switch <= sw;
    rst_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    m_addr = ~sw;
    m_p2p = m_addr == 8'hff;
    m_sel = 1'b0;
    st = 0;
    mq.delete();
    @(negedge core_clk);
    check_byte("subsystem_addr", m_addr, subsystem_addr);
    check_bit("p2p_mode", m_p2p, p2p_mode);
    check_bit("selected_flag", 1'b0, selected_flag);
    check_bit("md_tx_enable", 1'b0, md_tx_enable);
    @(posedge core_clk);
  endtask : do_reset
  task automatic final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    err_count++;
    final_report();
  end
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    char_poll_function = 1'b0;
    line_req = 1'b0;
    tx_char = 8'h00;
    tx_valid = 1'b0;
    busy_len = 8'h03;
    err_count = 0;
    compares = 0;
    seen_cnt = 0;
    void'($urandom(38444));
    a = $urandom_range(253, 1);
    address_switch = ~a[7:0];
    @(posedge core_clk);
    do_reset(~a[7:0]);
    send_str("Z");
    poll();
    line_req <= 1'b1;
    send_str("ab\r");
    repeat (3) begin
      @(negedge core_clk);
      check_bit("line_char_valid", 1'b0, line_char_valid);
    end
    @(posedge core_clk);
    line_req <= 1'b0;
    logon($sformatf("/%0d,", a + 1), 1);
    logon($sformatf("/%03d5", a), 1);
    logon("/300,", 0);
    logon("/,", 0);
    send_str("Q");
    poll();
    send_str($sformatf("%c\r", 8'($urandom_range(122, 97))));
    read_line();
    send_tx(8'($urandom));
    // Fifteen letters and CR fill the buffer to the brim
    repeat (15) send_str($sformatf("%c", 8'($urandom_range(122, 97))));
    send_str("\r");
    check_bit("rx_ready", 1'b0, rx_ready);
    read_line();
    send_str("xy");
    logon($sformatf("/%0d;", a), 1);
    check_bit("line_redo", m_redo, line_redo);
    send_str("k\r");
    read_line();
    busy_len <= 8'h28;
    send_tx(8'h55);
    logon($sformatf("/%0d,", a + 1), 1);
    check_bit("md_tx_enable", 1'b1, md_tx_enable);
    repeat (45) @(posedge core_clk);
    check_bit("md_tx_enable", 1'b0, md_tx_enable);
    busy_len <= 8'h02;
    send_tx(8'h41);
    address_switch <= ~a[7:0] ^ 8'h01;
    repeat (5) @(posedge core_clk);
    check_byte("subsystem_addr", a[7:0], subsystem_addr);
    do_reset(8'h00);
    send_str("/7,\r");
    read_line();
    send_tx(8'h42);
    check_byte("master stalls", 8'h00, 8'(mm.stalls));
    final_report();
  end
endmodule : multidrop_logon_select_tb_top
